// >>> ismu_pkg.sv
package ismu_pkg;

    // Register indices on the device register port.
    localparam logic [2:0] REG_INT_FLAGS   = 3'h0;
    localparam logic [2:0] REG_INT_MASK    = 3'h1;
    localparam logic [2:0] REG_TEMP_INT    = 3'h2;
    localparam logic [2:0] REG_TEMP_REM1   = 3'h3;
    localparam logic [2:0] REG_TEMP_REM2   = 3'h4;
    localparam logic [2:0] REG_GPI_STAT_LO = 3'h5;
    localparam logic [2:0] REG_GPI_STAT_HI = 3'h6;

    localparam int ADDR_W    = 3;
    localparam int DATA_W    = 16;
    localparam int TEMP_W    = 12;
    localparam int TEMP_N    = 3;
    localparam int GPI_PORTS = 20;
    localparam int GPI_LO_N  = 16;
    localparam int GPI_HI_N  = 4;

    // Flag and mask bit positions, shared by the flag and mask registers.
    localparam int BIT_SWEEP_DONE   = 0;
    localparam int BIT_DATA_READY   = 1;
    localparam int BIT_DATA_MISSED  = 2;
    localparam int BIT_GPI_READY    = 3;
    localparam int BIT_GPI_MISSED   = 4;
    localparam int BIT_OVERCURRENT  = 5;
    localparam int BIT_TEMP_BASE    = 6;
    localparam int TEMP_FLAG_N      = 3;
    localparam int BIT_SUPPLY_MON   = 15;
    localparam int TFLAG_NEW        = 0;
    localparam int TFLAG_LOW        = 1;
    localparam int TFLAG_HIGH       = 2;

    localparam logic [15:0] MASK_RST = 16'hffff;

    // Edge-mode codes per GPI port.
    localparam logic [1:0] GPI_MODE_NONE = 2'h0;
    localparam logic [1:0] GPI_MODE_RISE = 2'h1;
    localparam logic [1:0] GPI_MODE_FALL = 2'h2;
    localparam logic [1:0] GPI_MODE_BOTH = 2'h3;

    // Sweep-end pulse: 100 ns at a 50 ns clock period.
    localparam int         CLK_PERIOD_NS   = 50;
    localparam int         SWEEP_PULSE_NS  = 100;
    localparam int         SWEEP_PULSE_INT = (SWEEP_PULSE_NS / CLK_PERIOD_NS < 1) ? 1
                                             : SWEEP_PULSE_NS / CLK_PERIOD_NS;
    localparam logic [2:0] SWEEP_PULSE_CYC = SWEEP_PULSE_INT[2:0];

    typedef enum logic [1:0] {
        GCLR_IDLE,
        GCLR_ARMED,
        GCLR_GOT_LO,
        GCLR_GOT_HI
    } ismu_gclr_e;

endpackage : ismu_pkg

// >>> ismu_gpi_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ismu_gpi_if #(
    parameter int N = 20
);
    logic [N-1:0]   level;
    logic [2*N-1:0] mode;
    logic [N-1:0]   event_hit;

    modport det (input level, input mode, output event_hit);
    modport ctl (output level, output mode, input event_hit);
endinterface : ismu_gpi_if

`default_nettype wire

// >>> ismu_gpi_edge.sv
`timescale 1ns/1ps
`default_nettype none

module ismu_gpi_edge #(
    parameter int N = 20
) (
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    ismu_gpi_if.det   gpi
);

    logic [N-1:0] prev_q;
    logic         primed_q;

    // The first sample after reset only seeds the history, so a high pin is not seen as a rise.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_q   <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= gpi.level;
            primed_q <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_port
            logic rise;
            logic fall;
            logic [1:0] md;
            assign rise = primed_q && gpi.level[g] && !prev_q[g];
            assign fall = primed_q && !gpi.level[g] && prev_q[g];
            assign md   = gpi.mode[2*g +: 2];
            always_comb begin
                case (md)
                    ismu_pkg::GPI_MODE_NONE: gpi.event_hit[g] = 1'b0;
                    ismu_pkg::GPI_MODE_RISE: gpi.event_hit[g] = rise;
                    ismu_pkg::GPI_MODE_FALL: gpi.event_hit[g] = fall;
                    ismu_pkg::GPI_MODE_BOTH: gpi.event_hit[g] = rise || fall;
                    default:                 gpi.event_hit[g] = 1'b0;
                endcase
            end

            chk_mode_none_quiet: assert property (
                @(posedge sys_clk_i) disable iff (!arst_n_i)
                (md == ismu_pkg::GPI_MODE_NONE) |-> !gpi.event_hit[g])
                else $error("GPI event raised on a port in never mode.");
            chk_rise_detect: assert property (
                @(posedge sys_clk_i) disable iff (!arst_n_i)
                (primed_q && md == ismu_pkg::GPI_MODE_RISE && $rose(gpi.level[g])) |-> gpi.event_hit[g])
                else $error("Rising edge missed on a rise-mode port.");
        end
    endgenerate

endmodule : ismu_gpi_edge

`default_nettype wire

// >>> ismu_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Each of the three temperature results reads back as a 12-bit two's complement value in bits 11:0, 0.125 C per LSB.
// - A GPI port's status bit is set when the port sees the event its edge mode selects.
// - GPI status of ports 0-15 sits in bits 15:0 of the low register and ports 16-19 in bits 3:0 of the high one.
// - GPI status capture ignores the interrupt mask; the mask only gates the interrupt output.
// - GPI status clears only after a flag register read followed by reads of both GPI status registers.
// - A mask bit of 1 keeps its flag off the interrupt output and a 0 lets it through.
// - Mask bits 0, 1 and 2 gate the sweep-done, data-ready and data-missed flags.
// - In continuous-sweep mode every sweep end pulses the interrupt output low for 100 ns regardless of the flag.
// - Mask bit 3 gates the GPI event-ready flag and, while set, keeps mask bit 4 from being cleared.
// - Mask bit 4 can only be cleared while mask bit 3 is clear; a clear attempted otherwise is refused.
// - Mask bit 5 gates the driver overcurrent flag.
// - Temperature flag masks sit bitwise at 8:6, 11:9 and 14:12 for the internal and two remote sensors.
// - Mask bit 15 gates the supply monitor flag.
// - Each temperature triple sets bit 2 above high, bit 1 below low, bit 0 on a new reading; a flag read clears them.
// - The edge-mode code selects never, rising, falling or either edge for setting a port's status bit.
module ismu_top (
    input  wire logic                                          sys_clk_i,
    input  wire logic                                          arst_n_i,
    input  wire logic [ismu_pkg::ADDR_W-1:0]                   reg_addr_i,
    input  wire logic                                          reg_rd_i,
    input  wire logic                                          reg_wr_i,
    input  wire logic [ismu_pkg::DATA_W-1:0]                   reg_wdata_i,
    output logic      [ismu_pkg::DATA_W-1:0]                   reg_rdata_o,
    input  wire logic [ismu_pkg::TEMP_N-1:0]                   temp_valid_i,
    input  wire logic [ismu_pkg::TEMP_N-1:0][ismu_pkg::TEMP_W-1:0] temp_value_i,
    input  wire logic [ismu_pkg::TEMP_N-1:0][ismu_pkg::TEMP_W-1:0] temp_high_i,
    input  wire logic [ismu_pkg::TEMP_N-1:0][ismu_pkg::TEMP_W-1:0] temp_low_i,
    input  wire logic [ismu_pkg::GPI_PORTS-1:0]                gpi_level_i,
    input  wire logic [2*ismu_pkg::GPI_PORTS-1:0]              gpi_edge_mode_i,
    input  wire logic                                          sweep_done_i,
    input  wire logic                                          cont_sweep_i,
    input  wire logic                                          conv_data_ready_i,
    input  wire logic                                          conv_data_missed_i,
    input  wire logic                                          driver_overcurrent_i,
    input  wire logic                                          supply_monitor_i,
    output logic                                               irq_n_o
);

    localparam int NP = ismu_pkg::GPI_PORTS;

    logic [ismu_pkg::TEMP_N-1:0][ismu_pkg::TEMP_W-1:0] temp_q;
    logic [NP-1:0]                                     status_q;
    logic [15:0]                                       flags_q;
    logic [15:0]                                       mask_q;
    logic [15:0]                                       flag_set;
    logic [2:0]                                        pulse_cnt_q;
    ismu_pkg::ismu_gclr_e                              gclr_q;
    logic                                              rd_flags;
    logic                                              rd_lo;
    logic                                              rd_hi;
    logic                                              wr_mask;
    logic                                              gpi_clr;
    logic                                              irq_cause;

    ismu_gpi_if #(.N(NP)) gpi ();

    assign gpi.level = gpi_level_i;
    assign gpi.mode  = gpi_edge_mode_i;

    ismu_gpi_edge #(
        .N (NP)
    ) u_edge (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .gpi       (gpi)
    );

    function automatic logic addr_hit(input logic [ismu_pkg::ADDR_W-1:0] a,
                                      input logic [ismu_pkg::ADDR_W-1:0] idx);
        return a == idx;
    endfunction : addr_hit

    assign rd_flags = reg_rd_i && addr_hit(reg_addr_i, ismu_pkg::REG_INT_FLAGS);
    assign rd_lo    = reg_rd_i && addr_hit(reg_addr_i, ismu_pkg::REG_GPI_STAT_LO);
    assign rd_hi    = reg_rd_i && addr_hit(reg_addr_i, ismu_pkg::REG_GPI_STAT_HI);
    assign wr_mask  = reg_wr_i && addr_hit(reg_addr_i, ismu_pkg::REG_INT_MASK);

    // Temperature results are held until the engine delivers a new sample.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            temp_q <= '0;
        end else begin
            for (int s = 0; s < ismu_pkg::TEMP_N; s++) begin
                if (temp_valid_i[s]) begin
                    temp_q[s] <= temp_value_i[s];
                end
            end
        end
    end

    // Sources of the flag register, one bit per interrupt cause.
    always_comb begin
        flag_set                            = '0;
        flag_set[ismu_pkg::BIT_SWEEP_DONE]  = sweep_done_i;
        flag_set[ismu_pkg::BIT_DATA_READY]  = conv_data_ready_i;
        flag_set[ismu_pkg::BIT_DATA_MISSED] = conv_data_missed_i;
        flag_set[ismu_pkg::BIT_GPI_READY]   = |gpi.event_hit;
        flag_set[ismu_pkg::BIT_GPI_MISSED]  = |(gpi.event_hit & status_q & ~{NP{gpi_clr}});
        flag_set[ismu_pkg::BIT_OVERCURRENT] = driver_overcurrent_i;
        flag_set[ismu_pkg::BIT_SUPPLY_MON]  = supply_monitor_i;
        for (int s = 0; s < ismu_pkg::TEMP_N; s++) begin
            if (temp_valid_i[s]) begin
                flag_set[ismu_pkg::BIT_TEMP_BASE + 3*s + ismu_pkg::TFLAG_NEW]  = 1'b1;
                flag_set[ismu_pkg::BIT_TEMP_BASE + 3*s + ismu_pkg::TFLAG_HIGH] =
                    $signed(temp_value_i[s]) > $signed(temp_high_i[s]);
                flag_set[ismu_pkg::BIT_TEMP_BASE + 3*s + ismu_pkg::TFLAG_LOW]  =
                    $signed(temp_value_i[s]) < $signed(temp_low_i[s]);
            end
        end
    end

    // A flag read clears every flag, but a cause arriving in that cycle still lands.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~{16{rd_flags}}) | flag_set;
        end
    end

    // Status capture is blind to the mask register.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~{NP{gpi_clr}}) | gpi.event_hit;
        end
    end

    // Clear sequence: a flag read arms it, then both status registers must be read in either order.
    assign gpi_clr = (gclr_q == ismu_pkg::GCLR_GOT_LO && rd_hi) ||
                     (gclr_q == ismu_pkg::GCLR_GOT_HI && rd_lo);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gclr_q <= ismu_pkg::GCLR_IDLE;
        end else if (rd_flags) begin
            gclr_q <= ismu_pkg::GCLR_ARMED;
        end else begin
            case (gclr_q)
                ismu_pkg::GCLR_IDLE: begin
                    gclr_q <= ismu_pkg::GCLR_IDLE;
                end
                ismu_pkg::GCLR_ARMED: begin
                    if (rd_lo) begin
                        gclr_q <= ismu_pkg::GCLR_GOT_LO;
                    end else if (rd_hi) begin
                        gclr_q <= ismu_pkg::GCLR_GOT_HI;
                    end
                end
                ismu_pkg::GCLR_GOT_LO: begin
                    if (rd_hi) begin
                        gclr_q <= ismu_pkg::GCLR_IDLE;
                    end
                end
                ismu_pkg::GCLR_GOT_HI: begin
                    if (rd_lo) begin
                        gclr_q <= ismu_pkg::GCLR_IDLE;
                    end
                end
                default: begin
                    gclr_q <= ismu_pkg::GCLR_IDLE;
                end
            endcase
        end
    end

    // Mask register; the missed-event mask stays set while the ready mask is set.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_q <= ismu_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_q <= reg_wdata_i;
            if (mask_q[ismu_pkg::BIT_GPI_READY]) begin
                mask_q[ismu_pkg::BIT_GPI_MISSED] <= mask_q[ismu_pkg::BIT_GPI_MISSED]
                                                    | reg_wdata_i[ismu_pkg::BIT_GPI_MISSED];
            end
        end
    end

    // Sweep-end pulse counter, independent of the sweep-done flag.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_cnt_q <= '0;
        end else if (sweep_done_i && cont_sweep_i) begin
            pulse_cnt_q <= ismu_pkg::SWEEP_PULSE_CYC;
        end else if (pulse_cnt_q != '0) begin
            pulse_cnt_q <= pulse_cnt_q - 3'h1;
        end
    end

    assign irq_cause = |(flags_q & ~mask_q);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_n_o <= 1'b1;
        end else begin
            irq_n_o <= !(irq_cause || pulse_cnt_q != '0);
        end
    end

    // Read data returns one cycle after the read strobe; unused indices read zero.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ismu_pkg::REG_INT_FLAGS:   reg_rdata_o <= flags_q;
                ismu_pkg::REG_INT_MASK:    reg_rdata_o <= mask_q;
                ismu_pkg::REG_TEMP_INT:    reg_rdata_o <= {4'h0, temp_q[0]};
                ismu_pkg::REG_TEMP_REM1:   reg_rdata_o <= {4'h0, temp_q[1]};
                ismu_pkg::REG_TEMP_REM2:   reg_rdata_o <= {4'h0, temp_q[2]};
                ismu_pkg::REG_GPI_STAT_LO: reg_rdata_o <= status_q[ismu_pkg::GPI_LO_N-1:0];
                ismu_pkg::REG_GPI_STAT_HI: reg_rdata_o <= {12'h000, status_q[NP-1:ismu_pkg::GPI_LO_N]};
                default:                   reg_rdata_o <= '0;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    chk_temp_hold: assert property (
        !temp_valid_i[0] |=> $stable(temp_q[0]))
        else $error("Internal temperature result changed without a new sample.");

    chk_status_capture: assert property (
        (gpi.event_hit != '0) |=> ((status_q & $past(gpi.event_hit)) == $past(gpi.event_hit)))
        else $error("GPI event not captured in status.");

    chk_status_fall: assert property (
        (|($past(status_q) & ~status_q)) |-> $past(gpi_clr))
        else $error("GPI status cleared outside the read sequence.");

    chk_clear_sequence: assert property (
        (rd_flags ##1 !rd_hi ##1 rd_lo ##1 !(rd_flags || rd_hi) ##1 (rd_hi && gpi.event_hit == '0))
        |=> (status_q == '0))
        else $error("GPI status kept after flag and both status reads.");

    chk_missed_refuse: assert property (
        (wr_mask && mask_q[ismu_pkg::BIT_GPI_READY] && mask_q[ismu_pkg::BIT_GPI_MISSED])
        |=> mask_q[ismu_pkg::BIT_GPI_MISSED])
        else $error("Missed-event mask cleared while ready mask was set.");

    chk_irq_assert: assert property (
        irq_cause |=> !irq_n_o)
        else $error("Unmasked flag did not pull the interrupt low.");

    chk_irq_release: assert property (
        (!irq_cause && pulse_cnt_q == '0) |=> irq_n_o)
        else $error("Interrupt held low with no unmasked cause.");

    chk_sweep_pulse: assert property (
        (sweep_done_i && cont_sweep_i) |-> ##2 (!irq_n_o) [*2])
        else $error("Sweep-end pulse shorter than 100 ns.");

    chk_flag_clear: assert property (
        (rd_flags && flag_set == '0) |=> (flags_q == '0))
        else $error("Flag read did not clear the flags.");

    chk_rdata_hold: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("Read data changed without a read.");

    chk_temp_load: assert property (
        temp_valid_i[1] |=> (temp_q[1] == $past(temp_value_i[1])))
        else $error("Remote temperature sample not taken.");

    chk_temp_read: assert property (
        (reg_rd_i && reg_addr_i == ismu_pkg::REG_TEMP_REM2) |=> (reg_rdata_o == {4'h0, $past(temp_q[2])}))
        else $error("Temperature read-back wrong.");

    chk_status_lo_read: assert property (
        rd_lo |=> (reg_rdata_o == $past(status_q[ismu_pkg::GPI_LO_N-1:0])))
        else $error("Low GPI status read-back wrong.");

    chk_status_hi_read: assert property (
        rd_hi |=> (reg_rdata_o == {12'h000, $past(status_q[NP-1:ismu_pkg::GPI_LO_N])}))
        else $error("High GPI status read-back wrong.");

    chk_ready_flag: assert property (
        (gpi.event_hit != '0) |=> flags_q[ismu_pkg::BIT_GPI_READY])
        else $error("GPI event did not raise the ready flag.");

    chk_missed_flag: assert property (
        (|(gpi.event_hit & status_q) && !gpi_clr) |=> flags_q[ismu_pkg::BIT_GPI_MISSED])
        else $error("Repeated GPI event did not raise the missed flag.");

    chk_mask_write: assert property (
        (wr_mask && !mask_q[ismu_pkg::BIT_GPI_READY]) |=> (mask_q == $past(reg_wdata_i)))
        else $error("Mask write not taken.");

    chk_mask_hold: assert property (
        !wr_mask |=> $stable(mask_q))
        else $error("Mask changed without a write.");

    chk_pulse_load: assert property (
        (sweep_done_i && cont_sweep_i) |=> (pulse_cnt_q == ismu_pkg::SWEEP_PULSE_CYC))
        else $error("Sweep-end pulse counter not loaded.");

    chk_pulse_drive: assert property (
        (pulse_cnt_q != '0) |=> !irq_n_o)
        else $error("Sweep-end pulse did not drive the interrupt low.");

    chk_pulse_idle: assert property (
        (!cont_sweep_i && pulse_cnt_q == '0) |=> (pulse_cnt_q == '0))
        else $error("Sweep-end pulse started outside continuous sweep.");

    chk_new_flag: assert property (
        temp_valid_i[0] |=> flags_q[ismu_pkg::BIT_TEMP_BASE + ismu_pkg::TFLAG_NEW])
        else $error("New-reading flag not set.");

    chk_remote2_flag: assert property (
        temp_valid_i[2] |=> flags_q[ismu_pkg::BIT_TEMP_BASE + 2*ismu_pkg::TEMP_FLAG_N])
        else $error("Second remote new-reading flag not set.");

    chk_flag_sticky: assert property (
        !rd_flags |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("Flag cleared without a flag read.");

    chk_clear_arm: assert property (
        rd_flags |=> (gclr_q == ismu_pkg::GCLR_ARMED))
        else $error("Flag read did not arm the status clear.");

    chk_idle_keep: assert property (
        (gclr_q == ismu_pkg::GCLR_IDLE) |=> ((status_q & $past(status_q)) == $past(status_q)))
        else $error("GPI status cleared while the clear was not armed.");

    chk_flag_readback: assert property (
        rd_flags |=> (reg_rdata_o == $past(flags_q)))
        else $error("Flag read-back wrong.");

    chk_supply_irq: assert property (
        (flags_q[ismu_pkg::BIT_SUPPLY_MON] && !mask_q[ismu_pkg::BIT_SUPPLY_MON]) |=> !irq_n_o)
        else $error("Unmasked supply flag did not pull the interrupt low.");

endmodule : ismu_top

`default_nettype wire

// >>> ismu_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the register port: one strobe per access, request held until the sampling edge.
module ismu_host (
    input  wire logic        sys_clk_i,
    input  wire logic [15:0] rdata_i,
    output logic      [2:0]  addr_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic      [15:0] wdata_o
);
    initial begin
        addr_o  = 3'h0;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        wdata_o = 16'h0000;
    end

    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge sys_clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask : rd_reg

    // Flag read first, then both status halves, so the status is released.
    task automatic read_gpi(output logic [15:0] f, output logic [15:0] lo, output logic [15:0] hi);
        rd_reg(3'h0, f);
        rd_reg(3'h5, lo);
        rd_reg(3'h6, hi);
    endtask : read_gpi
endmodule : ismu_host

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic             sys_clk;
    logic             arst_n;
    logic [2:0]       reg_addr;
    logic             reg_rd;
    logic             reg_wr;
    logic [15:0]      reg_wdata;
    logic [15:0]      reg_rdata;
    logic [2:0]       temp_valid;
    logic [2:0][11:0] temp_value;
    logic [2:0][11:0] temp_high;
    logic [2:0][11:0] temp_low;
    logic [19:0]      gpi_level;
    logic [39:0]      gpi_mode;
    logic [4:0]       cause;
    logic             cont_sweep;
    logic             irq_n;
    int               error_cnt;
    int               cmp_count;
    int               cyc;
    int               cbit [5] = '{0, 1, 2, 5, 15};

    ismu_top i_dut (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr), .reg_rd_i(reg_rd),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .temp_valid_i(temp_valid), .temp_value_i(temp_value), .temp_high_i(temp_high),
        .temp_low_i(temp_low), .gpi_level_i(gpi_level), .gpi_edge_mode_i(gpi_mode),
        .sweep_done_i(cause[0]), .cont_sweep_i(cont_sweep), .conv_data_ready_i(cause[1]),
        .conv_data_missed_i(cause[2]), .driver_overcurrent_i(cause[3]),
        .supply_monitor_i(cause[4]), .irq_n_o(irq_n)
    );

    ismu_host i_host (
        .sys_clk_i(sys_clk), .rdata_i(reg_rdata), .addr_o(reg_addr),
        .rd_o(reg_rd), .wr_o(reg_wr), .wdata_o(reg_wdata)
    );

    always #25 sys_clk = ~sys_clk;

    task automatic complete_run;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic chk_rd(input logic [2:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_host.rd_reg(a, d);
        check(d, exp, "register read");
    endtask : chk_rd

    task automatic chk_irq(input logic exp);
        check({15'h0000, irq_n}, {15'h0000, exp}, "interrupt output");
    endtask : chk_irq

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc

    task automatic pulse(input int i);
        @(posedge sys_clk);
        cause[i] <= 1'b1;
        @(posedge sys_clk);
        cause[i] <= 1'b0;
    endtask : pulse

    task automatic t_reset;
        chk_rd(3'h1, 16'hffff);
        chk_rd(3'h0, 16'h0000);
        chk_irq(1'b1);
    endtask : t_reset

    task automatic t_mask_walk;
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            wait_cyc(2);
            chk_irq(1'b1);
            i_host.wr_reg(3'h1, ~(16'h0001 << cbit[i]));
            wait_cyc(2);
            chk_irq(1'b0);
            chk_rd(3'h0, 16'h0001 << cbit[i]);
            wait_cyc(1);
            chk_irq(1'b1);
            i_host.wr_reg(3'h1, 16'hffff);
        end
    endtask : t_mask_walk

    task automatic t_temp;
        @(posedge sys_clk);
        temp_value <= {12'h005, 12'hf00, 12'h190};
        temp_high  <= {12'h100, 12'h100, 12'h0c8};
        temp_low   <= {12'hf00, 12'hf80, 12'hf00};
        temp_valid <= 3'h7;
        @(posedge sys_clk);
        temp_valid <= 3'h0;
        chk_rd(3'h2, 16'h0190);
        chk_rd(3'h3, 16'h0f00);
        chk_rd(3'h4, 16'h0005);
        i_host.wr_reg(3'h2, 16'h0abc);
        chk_rd(3'h2, 16'h0190);
        chk_rd(3'h7, 16'h0000);
        i_host.wr_reg(3'h1, 16'hefff);
        wait_cyc(2);
        chk_irq(1'b0);
        chk_rd(3'h0, 16'h1740);
        wait_cyc(1);
        chk_irq(1'b1);
        chk_rd(3'h0, 16'h0000);
        i_host.wr_reg(3'h1, 16'hffff);
    endtask : t_temp

    task automatic t_gpi;
        logic [15:0] f;
        logic [15:0] lo;
        logic [15:0] hi;
        chk_rd(3'h5, 16'h0000);
        chk_rd(3'h6, 16'h0000);
        @(posedge sys_clk);
        gpi_level <= 20'h3000d;
        wait_cyc(3);
        chk_irq(1'b1);
        chk_rd(3'h5, 16'h0007);
        chk_rd(3'h6, 16'h0002);
        chk_rd(3'h5, 16'h0007);
        @(posedge sys_clk);
        gpi_level <= 20'h30009;
        i_host.read_gpi(f, lo, hi);
        check(f, 16'h0018, "gpi flag");
        check(lo, 16'h0007, "gpi low");
        check(hi, 16'h0002, "gpi high");
        chk_rd(3'h5, 16'h0000);
        chk_rd(3'h6, 16'h0000);
        i_host.wr_reg(3'h1, 16'hfff7);
        @(posedge sys_clk);
        gpi_level <= 20'h3000e;
        wait_cyc(3);
        chk_irq(1'b0);
        i_host.read_gpi(f, lo, hi);
        check(f, 16'h0008, "gpi flag");
        check(lo, 16'h0004, "gpi low");
        check(hi, 16'h0000, "gpi high");
        wait_cyc(1);
        chk_irq(1'b1);
        i_host.wr_reg(3'h1, 16'hffff);
    endtask : t_gpi

    task automatic t_mask_order;
        i_host.wr_reg(3'h1, 16'hffe7);
        chk_rd(3'h1, 16'hfff7);
        i_host.wr_reg(3'h1, 16'hffe7);
        chk_rd(3'h1, 16'hffe7);
        i_host.wr_reg(3'h1, 16'hffff);
    endtask : t_mask_order

    task automatic t_sweep;
        cont_sweep <= 1'b1;
        pulse(0);
        wait_cyc(1);
        chk_irq(1'b0);
        wait_cyc(1);
        chk_irq(1'b0);
        wait_cyc(1);
        chk_irq(1'b1);
        cont_sweep <= 1'b0;
        chk_rd(3'h0, 16'h0001);
    endtask : t_sweep

    initial begin
        sys_clk    = 1'b0;
        arst_n     = 1'b0;
        temp_valid = 3'h0;
        temp_value = '0;
        temp_high  = '0;
        temp_low   = '0;
        gpi_level  = 20'h00002;
        gpi_mode   = 40'h06_0000_0039;
        cause      = 5'h00;
        cont_sweep = 1'b0;
        error_cnt  = 0;
        cmp_count  = 0;
        cyc        = 0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_mask_walk();
        t_temp();
        t_gpi();
        t_mask_order();
        t_sweep();
        complete_run();
    end
endmodule : tb_top

`default_nettype wire
